// >>> design/brm_pkg.sv
// Purpose: shared constants and types of the bridge reset manager
// Assumes: 10 MHz system clock
// Notes:   register offsets are byte addresses of configuration space
package brm_pkg;

    // clock and timing
    localparam int unsigned CLK_PERIOD_NS   = 100;
    localparam int unsigned POR_CLK_WAIT_US = 10;
    localparam int unsigned TRAIN_LIMIT_MS  = 80;
    // least time: rounds up
    localparam int unsigned POR_CLK_WAIT_CYC =
        (POR_CLK_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // longest time: rounds down
    localparam int unsigned TRAIN_LIMIT_CYC =
        (TRAIN_LIMIT_MS * 1000000) / CLK_PERIOD_NS;

    // register map
    localparam logic [7:0]  SEC_BUS_CTL_OFS   = 8'h3e;
    localparam int unsigned SEC_RST_CTL_POS   = 6;
    localparam logic [15:0] SEC_BUS_CTL_RESET = 16'h0000;
    localparam logic [15:0] RD_UNMAPPED       = 16'h0000;

    // width of the static configuration strap group
    localparam int unsigned STATIC_W     = 8;
    localparam logic [STATIC_W-1:0] STATIC_RESET = 8'h00;

    // configuration access request
    typedef struct packed {
        logic        sel;
        logic        wr;
        logic [7:0]  addr;
        logic [1:0]  byteEn;
        logic [15:0] wrData;
    } brm_cfg_req_t;

    // reset outputs, widest scope first, all active low
    typedef struct packed {
        logic coldN;
        logic warmN;
        logic hotN;
    } brm_rst_t;

    // power-on sequencer states
    typedef enum logic [1:0] {
        PorPowerWait,
        PorClockWait,
        PorSettle,
        PorDone
    } brm_por_state_t;

    // link start sequencer states
    typedef enum logic [1:0] {
        LnkIdle,
        LnkConfig,
        LnkTraining
    } brm_lnk_state_t;

endpackage

// >>> design/brm_reset_manager.sv
// Purpose: reset sources, scopes and secondary bus reset of the bridge
// Assumes: pins are asynchronous to clk_sys; hot reset comes from the
//          link layer on clk_sys
// Notes:   reset scopes nest: cold covers warm covers hot
//
// Functional notes
// - Hold power-on reset until core supply monitor reports ninety percent.
// - Then release power-on reset 10 us after reference clock is active.
// - Power-on reset clears all registers, machines, sticky and power state.
// - Low global reset input starts power-on reset asynchronously, any power.
// - Global reset low holds every register, machine and sticky bit default.
// - Secondary bus reset asserted during power-on, global, link or hot reset.
// - Global reset release latches all static configuration inputs.
// - Global or link reset release starts EEPROM download if one present.
// - After global reset release, link configuration starts within 80 ms.
// - Low link reset input creates the internal conventional reset.
// - Link reset clears non-sticky bits and non-sticky, non-aux machines.
// - Link reset rising edge means power good, latch straps, configure.
// - After link reset release, link training begins within 80 ms.
// - Received hot reset moves the link interface into DL_DOWN.
// - DL_DOWN resets rest except sticky, EEPROM-loadable and aux power parts.
// - Secondary reset control bit 6 at 3Eh drives secondary bus reset.
// - Global reset asynchronously clears all logic including sticky bits.
`timescale 1ns/100ps
module brm_reset_manager
    import brm_pkg::*;
#(
    parameter int unsigned TRAIN_LIMIT = TRAIN_LIMIT_CYC,
    parameter int unsigned CLK_WAIT    = POR_CLK_WAIT_CYC
)
(
    // clock and board reset
    input  wire logic                clk_sys,
    input  wire logic                resetn,
    // reset pins
    input  wire logic                globalAsyncResetInN,
    input  wire logic                linkResetInN,
    // power and clock monitors
    input  wire logic                coreSupplyMonitor,
    input  wire logic                refClkActive,
    // static configuration straps
    input  wire logic [STATIC_W-1:0] staticCfgIn,
    // link layer
    input  wire logic                hotResetRcvd,
    input  wire logic                linkUp,
    // serial EEPROM loader
    input  wire logic                eepromPresent,
    input  wire logic                eepromDone,
    // configuration register access
    input  wire brm_cfg_req_t        cfgReq,
    output logic [15:0]              cfgRdData,
    // reset scopes for the rest of the bridge
    output brm_rst_t                 rstOut,
    output logic                     dlDown,
    output logic                     sysPowerGood,
    output logic [STATIC_W-1:0]      staticCfgLatched,
    output logic                     eepromLoadStart,
    output logic                     linkTrainStart,
    // secondary bus
    output logic                     secondaryBusResetOutN
);

    // asynchronous reset assertion terms
    wire coldAsyncN;
    wire warmAsyncN;
    // reset synchroniser chains
    logic [1:0] coldSync;
    logic [1:0] warmSync;
    logic       coldRelN;
    logic       warmRelN;
    // pin synchronisers
    logic [1:0] supplySync;
    logic [1:0] clkActSync;
    logic [1:0] eepromSync;
    logic [1:0] linkPinSync;
    logic [1:0][STATIC_W-1:0] strapSync;
    wire        supplyGood;
    wire        clkActive;
    wire        eepromSeen;
    wire        linkPinHigh;
    // power-on sequencer
    brm_por_state_t porState;
    brm_por_state_t next_porState;
    logic [$clog2(CLK_WAIT+1)-1:0] porCount;
    wire  porActive;
    // hot reset and link state
    logic hotHold;
    wire  hotRstN;
    // release edge detection
    logic warmRelD;
    wire  warmRise;
    logic coldRelD;
    wire  coldRise;
    // link start sequencer
    brm_lnk_state_t lnkState;
    brm_lnk_state_t next_lnkState;
    logic [$clog2(TRAIN_LIMIT+1)-1:0] trainCount;
    wire  trainDeadline;

    // register file
    logic [15:0] secBusCtl;
    wire         ctlHit;
    wire         ctlWrite;
    wire  [15:0] wrMask;
    wire  [15:0] next_secBusCtl;
    wire         secRstCtlBit;

    // global pin enters the cold reset tree asynchronously
    assign coldAsyncN = resetn & globalAsyncResetInN;
    // link pin enters the warm reset tree asynchronously
    assign warmAsyncN = coldAsyncN & linkResetInN;

    // release of the cold reset synchronised
    always_ff @(posedge clk_sys or negedge coldAsyncN)
    begin
        if (!coldAsyncN)
            coldSync <= 2'b00;
        else
            coldSync <= {coldSync[0], 1'b1};
    end

    // release of the warm reset synchronised
    always_ff @(posedge clk_sys or negedge warmAsyncN)
    begin
        if (!warmAsyncN)
            warmSync <= 2'b00;
        else
            warmSync <= {warmSync[0], 1'b1};
    end
    assign coldRelN = coldSync[1];
    assign warmRelN = warmSync[1];

    // monitor pins, two flops each; cleared only by the cold tree
    always_ff @(posedge clk_sys or negedge coldRelN)
    begin
        if (!coldRelN)
        begin
            supplySync  <= 2'b00;
            clkActSync  <= 2'b00;
            eepromSync  <= 2'b00;
            linkPinSync <= 2'b00;
            strapSync   <= {2{STATIC_RESET}};
        end
        else
        begin
            supplySync  <= {supplySync[0], coreSupplyMonitor};
            clkActSync  <= {clkActSync[0], refClkActive};
            eepromSync  <= {eepromSync[0], eepromPresent};
            linkPinSync <= {linkPinSync[0], linkResetInN};
            strapSync   <= {strapSync[0], staticCfgIn};
        end
    end
    assign supplyGood  = supplySync[1];
    assign clkActive   = clkActSync[1];
    assign eepromSeen  = eepromSync[1];
    assign linkPinHigh = linkPinSync[1];

    // power-on sequencer: supply first, then a settled reference clock
    always_comb
    begin
        next_porState = porState;
        case (porState)
            PorPowerWait:
                if (supplyGood)
                    next_porState = PorClockWait;
            PorClockWait:
                if (!supplyGood)
                    next_porState = PorPowerWait;
                else if (clkActive)
                    next_porState = PorSettle;
            PorSettle:
                if (!supplyGood)
                    next_porState = PorPowerWait;
                else if (!clkActive)
                    next_porState = PorClockWait;
                else if (porCount == ($bits(porCount))'(CLK_WAIT - 1))
                    next_porState = PorDone;
            PorDone:
                next_porState = PorDone;
            default:
                next_porState = PorPowerWait;
        endcase
    end

    // a global reset restarts the whole power-on sequence
    always_ff @(posedge clk_sys or negedge coldRelN)
    begin
        if (!coldRelN)
            porState <= PorPowerWait;
        else
            porState <= next_porState;
    end

    always_ff @(posedge clk_sys or negedge coldRelN)
    begin
        if (!coldRelN)
            porCount <= '0;
        else if (porState != PorSettle)
            porCount <= '0;
        else
            porCount <= porCount + 1'b1;
    end
    // internal power-on reset stays asserted until settled
    assign porActive = (porState != PorDone);

    // cold scope: everything, sticky and aux power included
    assign rstOut.coldN = coldRelN & ~porActive;
    assign rstOut.warmN = rstOut.coldN & warmRelN;
    assign rstOut.hotN  = rstOut.warmN & hotRstN;

    // hot reset holds the link in DL_DOWN until it comes up again
    always_ff @(posedge clk_sys or negedge warmRelN)
    begin
        if (!warmRelN)
            hotHold <= 1'b0;
        else if (hotResetRcvd)
            hotHold <= 1'b1;
        else if (linkUp)
            hotHold <= 1'b0;
    end

    // remaining logic held in reset while DL_DOWN follows a received hot reset
    assign hotRstN = ~(hotHold | hotResetRcvd);

    always_ff @(posedge clk_sys or negedge warmRelN)
    begin
        if (!warmRelN)
            dlDown <= 1'b1;
        else if (hotResetRcvd)
            dlDown <= 1'b1;
        else if (linkUp)
            dlDown <= 1'b0;
    end

    // release edges, seen in the cold scope so a warm release is caught
    always_ff @(posedge clk_sys or negedge coldRelN)
    begin
        if (!coldRelN)
        begin
            warmRelD <= 1'b0;
            coldRelD <= 1'b0;
        end
        else
        begin
            warmRelD <= rstOut.warmN;
            coldRelD <= rstOut.coldN;
        end
    end
    assign warmRise = rstOut.warmN & ~warmRelD;
    assign coldRise = rstOut.coldN & ~coldRelD;

    // power good drops at once with the warm tree, not 2 edges late
    always_ff @(posedge clk_sys or negedge warmRelN)
    begin
        if (!warmRelN)
            sysPowerGood <= 1'b0;
        else if (!linkPinHigh)
            sysPowerGood <= 1'b0;
        else if (warmRise)
            sysPowerGood <= 1'b1;
    end

    // straps are stable by reset release, so sampled then
    always_ff @(posedge clk_sys or negedge coldRelN)
    begin
        if (!coldRelN)
            staticCfgLatched <= STATIC_RESET;
        else if (warmRise | coldRise)
            staticCfgLatched <= strapSync[1];
    end

    // download only after global or link release, never after hot
    always_ff @(posedge clk_sys or negedge coldRelN)
    begin
        if (!coldRelN)
            eepromLoadStart <= 1'b0;
        else
            eepromLoadStart <= warmRise & eepromSeen;
    end

    // link start: configure, wait for the loader, never past the deadline
    assign trainDeadline =
        (trainCount == ($bits(trainCount))'(TRAIN_LIMIT - 1));
    always_comb
    begin
        next_lnkState = lnkState;
        case (lnkState)
            LnkIdle:
                next_lnkState = LnkConfig;
            LnkConfig:
                if ((eepromDone | ~eepromSeen) | trainDeadline)
                    next_lnkState = LnkTraining;
            LnkTraining:
                next_lnkState = LnkTraining;
            default:
                next_lnkState = LnkIdle;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstOut.warmN)
    begin
        if (!rstOut.warmN)
            lnkState <= LnkIdle;
        else
            lnkState <= next_lnkState;
    end

    // count from release toward the training limit
    always_ff @(posedge clk_sys or negedge rstOut.warmN)
    begin
        if (!rstOut.warmN)
            trainCount <= '0;
        else if (lnkState == LnkConfig && !trainDeadline)
            trainCount <= trainCount + 1'b1;
    end

    always_ff @(posedge clk_sys or negedge rstOut.warmN)
    begin
        if (!rstOut.warmN)
            linkTrainStart <= 1'b0;
        else
            linkTrainStart <= (next_lnkState == LnkTraining);
    end

    // configuration access decode
    assign ctlHit   = cfgReq.sel & (cfgReq.addr == SEC_BUS_CTL_OFS);
    assign ctlWrite = ctlHit & cfgReq.wr;
    assign wrMask   = {{8{cfgReq.byteEn[1]}}, {8{cfgReq.byteEn[0]}}};
    assign next_secBusCtl =
        (secBusCtl & ~wrMask) | (cfgReq.wrData & wrMask);

    // bridge control is neither sticky nor loadable: any scope clears it
    always_ff @(posedge clk_sys or negedge rstOut.hotN)
    begin
        if (!rstOut.hotN)
            secBusCtl <= SEC_BUS_CTL_RESET;
        else if (ctlWrite)
            secBusCtl <= next_secBusCtl;
    end

    // read data registered; unmapped offsets read as zero
    always_ff @(posedge clk_sys or negedge rstOut.coldN)
    begin
        if (!rstOut.coldN)
            cfgRdData <= RD_UNMAPPED;
        else if (cfgReq.sel && !cfgReq.wr)
            cfgRdData <= ctlHit ? secBusCtl : RD_UNMAPPED;
    end
    assign secRstCtlBit = secBusCtl[SEC_RST_CTL_POS];

    // secondary bus reset from any scope or the control bit
    always_ff @(posedge clk_sys or negedge rstOut.hotN)
    begin
        if (!rstOut.hotN)
            secondaryBusResetOutN <= 1'b0;
        else
            secondaryBusResetOutN <= ~secRstCtlBit;
    end

endmodule

// >>> sim/brm_upstream_model.sv
// Purpose: upstream partner owning link reset and reference clock
// Assumes: bench asks for both through two request levels
// Notes:   clock only leaves while link reset is held
`timescale 1ns/100ps
module brm_upstream_model
(
    // clock
    input  wire logic clk_sys,
    // requests from the bench
    input  wire logic holdReset,
    input  wire logic clockOn,
    // link pins
    output logic      linkResetInN = 1'h0,
    output logic      refClkActive = 1'h0
);
    always_ff @(posedge clk_sys)
    begin
        linkResetInN <= !holdReset && refClkActive;
        refClkActive <= clockOn || linkResetInN;
    end
endmodule

// >>> sim/brm_reset_manager_chk.sv
// Purpose: port checker of the bridge reset manager
// Assumes: one clock domain
// Notes:   bound onto every manager instance
`timescale 1ns/100ps
module brm_reset_manager_chk
    import brm_pkg::*;
#(
    parameter int unsigned TRAIN_LIMIT = 50,
    parameter int unsigned CLK_WAIT    = 5
)
(
    // clock and reset
    input wire logic                clk_sys,
    input wire logic                resetn,
    // inputs
    input wire logic                linkResetInN,
    input wire logic                coreSupplyMonitor,
    input wire logic                refClkActive,
    input wire logic                eepromPresent,
    input wire logic                hotResetRcvd,
    input wire logic [STATIC_W-1:0] staticCfgIn,
    input wire brm_cfg_req_t        cfgReq,
    // outputs
    input wire brm_rst_t            rstOut,
    input wire logic                dlDown,
    input wire logic                sysPowerGood,
    input wire logic [STATIC_W-1:0] staticCfgLatched,
    input wire logic                eepromLoadStart,
    input wire logic                linkTrainStart,
    input wire logic                secondaryBusResetOutN
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    logic        armed;
    logic        warmSeen;
    logic [15:0] trainWait;
    wire         ctlWr = cfgReq.sel && cfgReq.wr && cfgReq.byteEn[0]
                         && cfgReq.addr == SEC_BUS_CTL_OFS;

    // armed from a warm release until training may start
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            armed     <= 1'h0;
            warmSeen  <= 1'h0;
            trainWait <= 16'h0000;
        end
        else
        begin
            warmSeen  <= rstOut.warmN;
            armed     <= rstOut.warmN && !linkTrainStart
                         && (armed || !warmSeen);
            trainWait <= armed ? trainWait + 16'h0001 : 16'h0000;
        end
    end

    property p_coldSec;
        !rstOut.coldN |-> !secondaryBusResetOutN && !rstOut.warmN
                          && !rstOut.hotN;
    endproperty
    a_coldSec: assert property (p_coldSec)
        else $error("cold reset scope broken");

    property p_warmSec;
        !linkResetInN |-> !secondaryBusResetOutN && !rstOut.warmN
                          && !sysPowerGood;
    endproperty
    a_warmSec: assert property (p_warmSec)
        else $error("link reset not applied");

    property p_hotDl;
        hotResetRcvd |-> !rstOut.hotN ##1 dlDown && !secondaryBusResetOutN;
    endproperty
    a_hotDl: assert property (p_hotDl)
        else $error("hot reset not applied");

    property p_setBit;
        ctlWr && cfgReq.wrData[SEC_RST_CTL_POS] && rstOut.hotN
            |-> ##2 !secondaryBusResetOutN;
    endproperty
    a_setBit: assert property (p_setBit)
        else $error("control bit set but bus reset off");

    property p_clrBit;
        ctlWr && !cfgReq.wrData[SEC_RST_CTL_POS] && rstOut == 3'h7
            ##1 rstOut == 3'h7 |=> secondaryBusResetOutN;
    endproperty
    a_clrBit: assert property (p_clrBit)
        else $error("control bit clear but bus reset on");

    property p_warmRel;
        $rose(rstOut.warmN) && $past(rstOut.coldN)
            |=> sysPowerGood && staticCfgLatched == $past(staticCfgIn, 3);
    endproperty
    a_warmRel: assert property (p_warmRel)
        else $error("link release missed straps or power good");

    property p_loadStart;
        $rose(rstOut.warmN) && eepromPresent
            |=> eepromLoadStart ##1 !eepromLoadStart;
    endproperty
    a_loadStart: assert property (p_loadStart)
        else $error("loader start pulse wrong");

    property p_train;
        trainWait <= TRAIN_LIMIT + 4;
    endproperty
    a_train: assert property (p_train)
        else $error("training start late");

    property p_porWait;
        $rose(rstOut.coldN) |-> $past(refClkActive, CLK_WAIT)
                                && $past(coreSupplyMonitor, CLK_WAIT);
    endproperty
    a_porWait: assert property (p_porWait)
        else $error("power-on reset left early");
endmodule

bind brm_reset_manager brm_reset_manager_chk #(
    .TRAIN_LIMIT(TRAIN_LIMIT), .CLK_WAIT(CLK_WAIT)
) u_chk (
    .clk_sys(clk_sys), .resetn(resetn), .linkResetInN(linkResetInN),
    .coreSupplyMonitor(coreSupplyMonitor), .refClkActive(refClkActive),
    .eepromPresent(eepromPresent), .hotResetRcvd(hotResetRcvd),
    .staticCfgIn(staticCfgIn), .cfgReq(cfgReq), .rstOut(rstOut),
    .dlDown(dlDown), .sysPowerGood(sysPowerGood),
    .staticCfgLatched(staticCfgLatched), .eepromLoadStart(eepromLoadStart),
    .linkTrainStart(linkTrainStart),
    .secondaryBusResetOutN(secondaryBusResetOutN)
);

// >>> sim/tb_top.sv
// Purpose: self-checking bench of the bridge reset manager
// Assumes: short training and clock-wait counts
// Notes:   partner model owns link reset and reference clock
`timescale 1ns/100ps
module tb_top
    import brm_pkg::*;
;
    logic                clk_sys = 1'h0;
    logic                resetn, globalAsyncResetInN, coreSupplyMonitor;
    logic                hotResetRcvd, linkUp, eepromPresent, eepromDone;
    logic                holdReset, clockOn, linkResetInN, refClkActive;
    logic                dlDown, sysPowerGood, eepromLoadStart;
    logic                linkTrainStart, secondaryBusResetOutN;
    logic [STATIC_W-1:0] staticCfgIn, staticCfgLatched;
    brm_cfg_req_t        cfgReq;
    brm_rst_t            rstOut;
    logic [15:0]         cfgRdData, shadow, rd, d;
    logic [31:0]         r;
    logic [1:0]          be;
    integer              seed = 32'h0000_ebdd;
    int                  failures = 0, n_compared = 0, i, k;

    always #50 clk_sys = ~clk_sys;

    brm_reset_manager #(.TRAIN_LIMIT(50), .CLK_WAIT(5)) dut (
        .clk_sys(clk_sys), .resetn(resetn),
        .globalAsyncResetInN(globalAsyncResetInN),
        .linkResetInN(linkResetInN), .coreSupplyMonitor(coreSupplyMonitor),
        .refClkActive(refClkActive), .staticCfgIn(staticCfgIn),
        .hotResetRcvd(hotResetRcvd), .linkUp(linkUp),
        .eepromPresent(eepromPresent), .eepromDone(eepromDone),
        .cfgReq(cfgReq), .cfgRdData(cfgRdData), .rstOut(rstOut),
        .dlDown(dlDown), .sysPowerGood(sysPowerGood),
        .staticCfgLatched(staticCfgLatched),
        .eepromLoadStart(eepromLoadStart), .linkTrainStart(linkTrainStart),
        .secondaryBusResetOutN(secondaryBusResetOutN)
    );
    brm_upstream_model partner (
        .clk_sys(clk_sys), .holdReset(holdReset), .clockOn(clockOn),
        .linkResetInN(linkResetInN), .refClkActive(refClkActive)
    );

    function automatic logic [15:0] merge(input logic [15:0] o,
        input logic [1:0] b, input logic [15:0] v);
        return {b[1] ? v[15:8] : o[15:8], b[0] ? v[7:0] : o[7:0]};
    endfunction

    function automatic logic sec_exp(input logic [15:0] v);
        return !v[SEC_RST_CTL_POS];
    endfunction

    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp,
        input string what);
        n_compared++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got,
                exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string w);
        chk_word({15'h0000, got}, {15'h0000, exp}, w);
    endtask

    task automatic cfg_wr(input logic [7:0] a, input logic [1:0] b,
        input logic [15:0] v);
        @(posedge clk_sys);
        cfgReq <= '{1'h1, 1'h1, a, b, v};
        @(posedge clk_sys);
        cfgReq.sel <= 1'h0;
        repeat (2) @(posedge clk_sys);
    endtask

    task automatic cfg_rd(input logic [7:0] a, output logic [15:0] v);
        @(posedge clk_sys);
        cfgReq <= '{1'h1, 1'h0, a, 2'h3, 16'h0000};
        @(posedge clk_sys);
        cfgReq.sel <= 1'h0;
        @(negedge clk_sys);
        v = cfgRdData;
    endtask

    // after any release: training, straps, register, bus reset
    task automatic cold_up;
        for (i = 0; i < 400 && linkTrainStart !== 1'h1; i++)
            @(posedge clk_sys);
        @(negedge clk_sys);
        chk_bit(linkTrainStart, 1'h1, "training start");
        rd = {8'h00, staticCfgLatched};
        chk_word(rd, {8'h00, staticCfgIn}, "straps");
        cfg_rd(SEC_BUS_CTL_OFS, rd);
        chk_word(rd, shadow, "register default");
        chk_bit(secondaryBusResetOutN, 1'h1, "bus reset off");
    endtask

    task automatic tally_and_finish;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial
    begin
        {resetn, globalAsyncResetInN, coreSupplyMonitor, hotResetRcvd} = 4'h0;
        {linkUp, eepromPresent, eepromDone, clockOn} = 4'h0;
        holdReset = 1'h1;
        cfgReq = '0;
        shadow = SEC_BUS_CTL_RESET;
        r = $random(seed);
        staticCfgIn = r[7:0];
        repeat (4) @(posedge clk_sys);
        resetn <= 1'h1;
        globalAsyncResetInN <= 1'h1;
        repeat (3) @(posedge clk_sys);
        coreSupplyMonitor <= 1'h1;
        repeat (3) @(posedge clk_sys);
        {clockOn, linkUp, holdReset} <= 3'h6;
        cold_up;
        // first entries: set, high byte only, clear
        for (k = 0; k < 10; k++)
        begin
            r = $random(seed);
            be = k == 1 ? 2'h2 : (k < 3 ? 2'h1 : r[17:16]);
            d = k == 0 ? 16'h0040 : (k == 2 ? 16'h0000 : r[15:0]);
            cfg_wr(SEC_BUS_CTL_OFS, be, d);
            shadow = merge(shadow, be, d);
            cfg_rd(SEC_BUS_CTL_OFS, rd);
            chk_word(rd, shadow, "readback");
            chk_bit(secondaryBusResetOutN, sec_exp(shadow), "bit");
        end
        cfg_rd(8'h40, rd);
        chk_word(rd, RD_UNMAPPED, "unmapped");
        cfg_wr(SEC_BUS_CTL_OFS, 2'h3, 16'h5a5a);
        globalAsyncResetInN <= 1'h0;
        r = $random(seed);
        staticCfgIn <= r[7:0];
        @(negedge clk_sys);
        chk_bit(secondaryBusResetOutN, 1'h0, "global bus reset");
        chk_word({13'h0000, rstOut}, 16'h0000, "global scopes");
        @(posedge clk_sys);
        globalAsyncResetInN <= 1'h1;
        shadow = SEC_BUS_CTL_RESET;
        cold_up;
        cfg_wr(SEC_BUS_CTL_OFS, 2'h3, 16'h5a5a);
        {eepromPresent, holdReset} <= 2'h3;
        r = $random(seed);
        staticCfgIn <= r[7:0];
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        chk_bit(secondaryBusResetOutN, 1'h0, "link bus reset");
        chk_bit(rstOut.coldN, 1'h1, "cold kept");
        cfg_wr(SEC_BUS_CTL_OFS, 2'h3, 16'hffff);
        clockOn <= 1'h0;
        repeat (3) @(posedge clk_sys);
        {clockOn, holdReset} <= 2'h2;
        for (i = 0; i < 20 && eepromLoadStart !== 1'h1; i++)
            @(negedge clk_sys);
        chk_bit(eepromLoadStart, 1'h1, "loader start");
        chk_bit(sysPowerGood, 1'h1, "power good");
        chk_bit(linkTrainStart, 1'h0, "waits loader");
        @(posedge clk_sys);
        eepromDone <= 1'h1;
        shadow = SEC_BUS_CTL_RESET;
        cold_up;
        cfg_wr(SEC_BUS_CTL_OFS, 2'h1, 16'h0081);
        {linkUp, hotResetRcvd} <= 2'h1;
        @(posedge clk_sys);
        hotResetRcvd <= 1'h0;
        @(negedge clk_sys);
        chk_bit(dlDown, 1'h1, "link down state");
        chk_bit(secondaryBusResetOutN, 1'h0, "hot bus reset");
        chk_bit(rstOut.warmN, 1'h1, "warm kept");
        @(posedge clk_sys);
        linkUp <= 1'h1;
        for (i = 0; i < 20 && dlDown !== 1'h0; i++)
            @(posedge clk_sys);
        cfg_rd(SEC_BUS_CTL_OFS, rd);
        chk_word(rd, SEC_BUS_CTL_RESET, "hot clear");
        chk_bit(secondaryBusResetOutN, 1'h1, "hot release");
        // loader never finishes: training only at the deadline
        @(posedge clk_sys);
        {eepromDone, holdReset} <= 2'h1;
        repeat (4) @(posedge clk_sys);
        holdReset <= 1'h0;
        repeat (40) @(posedge clk_sys);
        @(negedge clk_sys);
        chk_bit(linkTrainStart, 1'h0, "before deadline");
        cold_up;
        tally_and_finish;
    end

    // whole run is well under a thousand cycles
    initial
    begin
        repeat (6000) @(posedge clk_sys);
        failures++;
        $display("CHECK FAILED %0t watchdog expired", $time);
        tally_and_finish;
    end
endmodule
